// [hdl/sbio_pkg.sv]
// constants, register map and types of the scan engine
// assumes one core clock; scan ticks and i/o data come from logic on it
// What this block does
// R1: ticks are accepted only while scan_enable is 1; it resets to 0
// R2: each enabled input slot reads its source once per scan start
// R3: filter_depth d>0: new level must be seen d+1 scans
// R4: filter_depth clamps at 4, needing 5 scans
// R5: filter_depth is per slot; all 32 bits of a slot share it
// R6: full 32-bit source word reaches hold after filter and force
// R7: holding bit 0 to 1 sets rise_pulse for that scan only
// R8: holding bit 1 to 0 sets fall_pulse for that scan only
// R9: sticky bits set on edges, cleared only by software or reset
// R10: sample_set_mask forces holding bits to 1, sample_clear_mask to 0
// R11: drive_set_mask bits go out as 1
// R12: drive_clear_mask bits go out as 0
// R13: when set and clear masks both select a bit, clear wins
// R14: per-class input summaries OR that class's sample masks
// R15: fast_drive_mask_any ORs drive masks of fast slots
// R16: slow_drive_mask_any ORs drive masks of slow slots
// R17: all_mask_any ORs every mask; nonzero means forcing is active
// R18: clear-forcing command and reset zero every forcing mask
// R19: output slots 0 to 63, each with dest_addr and hold word
// R20: output slots below fast_drive_count go in fast scan, others in slow
// R21: zero dest_addr stops that slot and all higher slots of its class
// R22: a fast-range zero leaves slow slots, which start at the count
// R23: each scan end writes the forced 32-bit word to active slots
// R24: a bit back at its held level restarts its count
package sbio_pkg;
    localparam int SLOTS = 64;
    localparam int DATA_W = 32;
    localparam int ADDR_W = 13;
    localparam int IO_ADDR_W = 32;
    localparam int CNT_W = 7;
    localparam int DEPTH_W = 3;
    localparam int SLOT_W = 6;
    localparam int FIELD_W = 4;
    localparam logic [DEPTH_W-1:0] DEPTH_MAX = 3'h4;
    localparam logic [CNT_W-1:0] SLOT_COUNT = 7'h40;
    localparam logic [CNT_W-1:0] FAST_COUNT_RST = 7'h00;
    // global registers, byte addresses
    localparam logic [ADDR_W-1:0] REG_CTRL = 13'h0000;
    localparam logic [ADDR_W-1:0] REG_FAST_IN_COUNT = 13'h0004;
    localparam logic [ADDR_W-1:0] REG_FAST_DRIVE_COUNT = 13'h0008;
    localparam logic [ADDR_W-1:0] REG_STATUS = 13'h000C;
    localparam logic [ADDR_W-1:0] REG_FAST_SAMPLE_ANY = 13'h0010;
    localparam logic [ADDR_W-1:0] REG_SLOW_SAMPLE_ANY = 13'h0014;
    localparam logic [ADDR_W-1:0] REG_FAST_DRIVE_ANY = 13'h0018;
    localparam logic [ADDR_W-1:0] REG_SLOW_DRIVE_ANY = 13'h001C;
    localparam logic [ADDR_W-1:0] REG_ALL_MASK_ANY = 13'h0020;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    // slot region: addr[12]=1, slot in addr[11:6], field in addr[5:2]
    localparam int SLOT_REGION_BIT = 12;
    localparam int SLOT_LSB = 6;
    localparam int FIELD_LSB = 2;
    localparam logic [FIELD_W-1:0] F_SRC_ADDR = 4'h0;
    localparam logic [FIELD_W-1:0] F_DEST_ADDR = 4'h1;
    localparam logic [FIELD_W-1:0] F_FILTER_DEPTH = 4'h2;
    localparam logic [FIELD_W-1:0] F_SAMPLE_SET = 4'h3;
    localparam logic [FIELD_W-1:0] F_SAMPLE_CLEAR = 4'h4;
    localparam logic [FIELD_W-1:0] F_DRIVE_SET = 4'h5;
    localparam logic [FIELD_W-1:0] F_DRIVE_CLEAR = 4'h6;
    localparam logic [FIELD_W-1:0] F_HOLD_IN = 4'h7;
    localparam logic [FIELD_W-1:0] F_OUT_HOLD = 4'h8;
    localparam logic [FIELD_W-1:0] F_RISE_PULSE = 4'h9;
    localparam logic [FIELD_W-1:0] F_FALL_PULSE = 4'hA;
    localparam logic [FIELD_W-1:0] F_RISE_STICKY = 4'hB;
    localparam logic [FIELD_W-1:0] F_FALL_STICKY = 4'hC;

    typedef enum logic [2:0] {
        ST_IDLE, ST_OUT_WR, ST_IN_RD, ST_IN_WAIT, ST_IN_CAP
    } sbio_state_t;

    // request to the memory-mapped i/o registers outside
    typedef struct packed {
        logic rd;
        logic wr;
        logic [IO_ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } sbio_io_req_t;

    typedef struct packed {
        sbio_state_t st;
        logic fast_cls;
        logic [CNT_W-1:0] idx;
        logic pend_fast;
        logic pend_slow;
        logic scan_enable;
        logic [CNT_W-1:0] fast_in_count;
        logic [CNT_W-1:0] fast_drive_count;
        logic [DATA_W-1:0] rdata;
        logic forcing_active;
        sbio_io_req_t io;
    } sbio_core_t;
endpackage : sbio_pkg

// [hdl/sbio_top.sv]
// scanned buffered i/o engine: slot tables, scan sequencer, register port
// assumes ticks, register port and i/o read data all run on core_clk
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module sbio_top (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic fast_tick,
    input wire logic slow_tick,
    input wire logic [sbio_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sbio_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [sbio_pkg::DATA_W-1:0] reg_rdata,
    output sbio_pkg::sbio_io_req_t io_req,
    input wire logic [sbio_pkg::DATA_W-1:0] io_rdata,
    output logic forcing_active
);
    import sbio_pkg::*;

    // clear beats set on a bit selected by both masks
    function automatic logic [DATA_W-1:0] force_apply(
        input logic [DATA_W-1:0] v,
        input logic [DATA_W-1:0] set_m,
        input logic [DATA_W-1:0] clr_m);
        force_apply = (v | set_m) & ~clr_m; // R13
    endfunction : force_apply

    function automatic logic [CNT_W-1:0] cls_start(
        input logic fast, input logic [CNT_W-1:0] cnt);
        cls_start = fast ? '0 : cnt; // R22
    endfunction : cls_start

    function automatic logic [CNT_W-1:0] cls_end(
        input logic fast, input logic [CNT_W-1:0] cnt);
        cls_end = fast ? cnt : SLOT_COUNT; // R20
    endfunction : cls_end

    function automatic logic [CNT_W-1:0] clamp_count(
        input logic [DATA_W-1:0] v);
        clamp_count = (v > DATA_W'(SLOT_COUNT)) ? SLOT_COUNT : v[CNT_W-1:0];
    endfunction : clamp_count

    // slot tables
    logic [IO_ADDR_W-1:0] src_mem [SLOTS];
    logic [IO_ADDR_W-1:0] dst_mem [SLOTS]; // R19
    logic [DEPTH_W-1:0] dep_mem [SLOTS];
    logic [DATA_W-1:0] sset_mem [SLOTS];
    logic [DATA_W-1:0] sclr_mem [SLOTS];
    logic [DATA_W-1:0] dset_mem [SLOTS];
    logic [DATA_W-1:0] dclr_mem [SLOTS];

    logic [DATA_W-1:0] filt_mem [SLOTS];
    logic [DATA_W-1:0] hold_mem [SLOTS];
    logic [DATA_W-1:0] out_mem [SLOTS];
    logic [DATA_W-1:0] rise_mem [SLOTS];
    logic [DATA_W-1:0] fall_mem [SLOTS];
    logic [DATA_W-1:0] rsty_mem [SLOTS];
    logic [DATA_W-1:0] fsty_mem [SLOTS];
    logic [DEPTH_W-1:0] cnt_mem [SLOTS][DATA_W];

    sbio_core_t r_reg;
    sbio_core_t r_next;

    // register port decode
    logic slot_hit;
    logic [SLOT_W-1:0] bus_slot;
    logic [FIELD_W-1:0] bus_field;
    logic slot_wr;
    logic clear_cmd;

    assign slot_hit = reg_addr[SLOT_REGION_BIT];
    assign bus_slot = reg_addr[SLOT_LSB +: SLOT_W];
    assign bus_field = reg_addr[FIELD_LSB +: FIELD_W];
    assign slot_wr = reg_wr && slot_hit;
    assign clear_cmd = reg_wr && !slot_hit && reg_addr == REG_CTRL &&
                       reg_wdata[CTRL_CLEAR_BIT]; // R18

    // slot under service and its class bounds
    logic [SLOT_W-1:0] cur_slot;
    logic [CNT_W-1:0] in_end;
    logic [CNT_W-1:0] out_end;

    assign cur_slot = r_reg.idx[SLOT_W-1:0];
    assign in_end = cls_end(r_reg.fast_cls, r_reg.fast_in_count);
    assign out_end = cls_end(r_reg.fast_cls, r_reg.fast_drive_count);

    // debounce and forcing of the word just read
    logic cap;
    logic [DATA_W-1:0] cap_filt;
    logic [DATA_W-1:0] cap_hold;
    logic [DATA_W-1:0] cap_rise;
    logic [DATA_W-1:0] cap_fall;
    logic [DEPTH_W-1:0] cap_cnt [DATA_W];

    always_comb begin
        cap = (r_reg.st == ST_IN_CAP);
        cap_filt = filt_mem[cur_slot];
        for (int b = 0; b < DATA_W; b++) begin
            cap_cnt[b] = '0;
            if (dep_mem[cur_slot] == '0) begin
                cap_filt[b] = io_rdata[b]; // R6
            end else if (io_rdata[b] == filt_mem[cur_slot][b]) begin
                cap_cnt[b] = '0; // R24
            end else if (cnt_mem[cur_slot][b] >= dep_mem[cur_slot]) begin
                cap_filt[b] = io_rdata[b]; // R3
            end else begin
                cap_cnt[b] = cnt_mem[cur_slot][b] + 3'h1; // R5
            end
        end
        cap_hold = force_apply(cap_filt, sset_mem[cur_slot],
                               sclr_mem[cur_slot]); // R10
        cap_rise = cap_hold & ~hold_mem[cur_slot]; // R7
        cap_fall = ~cap_hold & hold_mem[cur_slot]; // R8
    end

    // forcing summary words, class split per direction
    logic [DATA_W-1:0] fast_sample_mask_any;
    logic [DATA_W-1:0] slow_sample_mask_any;
    logic [DATA_W-1:0] fast_drive_mask_any;
    logic [DATA_W-1:0] slow_drive_mask_any;
    logic [DATA_W-1:0] all_mask_any;

    always_comb begin
        fast_sample_mask_any = '0;
        slow_sample_mask_any = '0;
        fast_drive_mask_any = '0;
        slow_drive_mask_any = '0;
        for (int i = 0; i < SLOTS; i++) begin
            if (CNT_W'(i) < r_reg.fast_in_count) begin
                fast_sample_mask_any |= sset_mem[i] | sclr_mem[i]; // R14
            end else begin
                slow_sample_mask_any |= sset_mem[i] | sclr_mem[i]; // R14
            end
            if (CNT_W'(i) < r_reg.fast_drive_count) begin
                fast_drive_mask_any |= dset_mem[i] | dclr_mem[i]; // R15
            end else begin
                slow_drive_mask_any |= dset_mem[i] | dclr_mem[i]; // R16
            end
        end
        all_mask_any = fast_sample_mask_any | slow_sample_mask_any |
                       fast_drive_mask_any | slow_drive_mask_any; // R17
    end

    // scan sequencer and global registers
    always_comb begin
        r_next = r_reg;
        r_next.io.rd = 1'b0;
        r_next.io.wr = 1'b0;
        // a tick during a scan waits; a second one in that time merges
        if (fast_tick && r_reg.scan_enable) begin
            r_next.pend_fast = 1'b1; // R1
        end
        if (slow_tick && r_reg.scan_enable) begin
            r_next.pend_slow = 1'b1; // R1
        end

        case (r_reg.st)
            ST_IDLE: begin
                // the fast class is served first when both wait
                if (r_next.pend_fast) begin
                    r_next.pend_fast = 1'b0;
                    r_next.fast_cls = 1'b1;
                    r_next.idx = '0;
                    r_next.st = ST_OUT_WR;
                end else if (r_next.pend_slow) begin
                    r_next.pend_slow = 1'b0;
                    r_next.fast_cls = 1'b0;
                    r_next.idx = r_reg.fast_drive_count; // R22
                    r_next.st = ST_OUT_WR;
                end
            end
            ST_OUT_WR: begin
                // a tick closes the previous scan, so outputs go first
                if (r_reg.idx >= out_end || dst_mem[cur_slot] == '0) begin
                    r_next.st = ST_IN_RD; // R21
                    r_next.idx = cls_start(r_reg.fast_cls,
                                           r_reg.fast_in_count);
                end else begin
                    r_next.io.wr = 1'b1; // R23
                    r_next.io.addr = dst_mem[cur_slot];
                    r_next.io.wdata = force_apply(out_mem[cur_slot],
                        dset_mem[cur_slot], dclr_mem[cur_slot]); // R11 R12
                    r_next.idx = r_reg.idx + 7'h01;
                end
            end
            ST_IN_RD: begin
                if (r_reg.idx >= in_end || src_mem[cur_slot] == '0) begin
                    r_next.st = ST_IDLE;
                end else begin
                    r_next.io.rd = 1'b1; // R2
                    r_next.io.addr = src_mem[cur_slot];
                    r_next.st = ST_IN_WAIT;
                end
            end
            ST_IN_WAIT: begin
                r_next.st = ST_IN_CAP; // data returns one cycle after rd
            end
            ST_IN_CAP: begin
                r_next.idx = r_reg.idx + 7'h01;
                r_next.st = ST_IN_RD;
            end
            default: begin
                r_next.st = ST_IDLE;
            end
        endcase

        // global register writes
        if (reg_wr && !slot_hit) begin
            if (reg_addr == REG_CTRL) begin
                r_next.scan_enable = reg_wdata[CTRL_ENABLE_BIT]; // R1
            end else if (reg_addr == REG_FAST_IN_COUNT) begin
                r_next.fast_in_count = clamp_count(reg_wdata);
            end else if (reg_addr == REG_FAST_DRIVE_COUNT) begin
                r_next.fast_drive_count = clamp_count(reg_wdata); // R20
            end
        end

        // register reads, answered in the next cycle
        r_next.rdata = '0;
        if (reg_rd && slot_hit) begin
            if (bus_field == F_SRC_ADDR) begin
                r_next.rdata = src_mem[bus_slot];
            end else if (bus_field == F_DEST_ADDR) begin
                r_next.rdata = dst_mem[bus_slot];
            end else if (bus_field == F_FILTER_DEPTH) begin
                r_next.rdata = DATA_W'(dep_mem[bus_slot]);
            end else if (bus_field == F_SAMPLE_SET) begin
                r_next.rdata = sset_mem[bus_slot];
            end else if (bus_field == F_SAMPLE_CLEAR) begin
                r_next.rdata = sclr_mem[bus_slot];
            end else if (bus_field == F_DRIVE_SET) begin
                r_next.rdata = dset_mem[bus_slot];
            end else if (bus_field == F_DRIVE_CLEAR) begin
                r_next.rdata = dclr_mem[bus_slot];
            end else if (bus_field == F_HOLD_IN) begin
                r_next.rdata = hold_mem[bus_slot];
            end else if (bus_field == F_OUT_HOLD) begin
                r_next.rdata = out_mem[bus_slot];
            end else if (bus_field == F_RISE_PULSE) begin
                r_next.rdata = rise_mem[bus_slot];
            end else if (bus_field == F_FALL_PULSE) begin
                r_next.rdata = fall_mem[bus_slot];
            end else if (bus_field == F_RISE_STICKY) begin
                r_next.rdata = rsty_mem[bus_slot];
            end else if (bus_field == F_FALL_STICKY) begin
                r_next.rdata = fsty_mem[bus_slot];
            end
        end else if (reg_rd) begin
            if (reg_addr == REG_CTRL) begin
                r_next.rdata[CTRL_ENABLE_BIT] = r_reg.scan_enable;
            end else if (reg_addr == REG_FAST_IN_COUNT) begin
                r_next.rdata = DATA_W'(r_reg.fast_in_count);
            end else if (reg_addr == REG_FAST_DRIVE_COUNT) begin
                r_next.rdata = DATA_W'(r_reg.fast_drive_count);
            end else if (reg_addr == REG_STATUS) begin
                r_next.rdata = {29'h0, r_reg.pend_slow, r_reg.pend_fast,
                                r_reg.st != ST_IDLE};
            end else if (reg_addr == REG_FAST_SAMPLE_ANY) begin
                r_next.rdata = fast_sample_mask_any;
            end else if (reg_addr == REG_SLOW_SAMPLE_ANY) begin
                r_next.rdata = slow_sample_mask_any;
            end else if (reg_addr == REG_FAST_DRIVE_ANY) begin
                r_next.rdata = fast_drive_mask_any;
            end else if (reg_addr == REG_SLOW_DRIVE_ANY) begin
                r_next.rdata = slow_drive_mask_any;
            end else if (reg_addr == REG_ALL_MASK_ANY) begin
                r_next.rdata = all_mask_any;
            end
        end

        r_next.forcing_active = |all_mask_any; // R17
    end

    // core state register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            r_reg <= '0;
            r_reg.st <= ST_IDLE;
            r_reg.fast_in_count <= FAST_COUNT_RST;
            r_reg.fast_drive_count <= FAST_COUNT_RST;
        end else begin
            r_reg <= r_next;
        end
    end

    // software sticky clears aimed at the slot in capture
    logic [DATA_W-1:0] rsty_wclr;
    logic [DATA_W-1:0] fsty_wclr;

    assign rsty_wclr = (slot_wr && bus_field == F_RISE_STICKY &&
                        bus_slot == cur_slot) ? reg_wdata : '0;
    assign fsty_wclr = (slot_wr && bus_field == F_FALL_STICKY &&
                        bus_slot == cur_slot) ? reg_wdata : '0;

    // slot tables: software writes, scan captures; reset clears all
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < SLOTS; i++) begin
                src_mem[i] <= '0;
                dst_mem[i] <= '0;
                dep_mem[i] <= '0;
                sset_mem[i] <= '0; // R18
                sclr_mem[i] <= '0;
                dset_mem[i] <= '0;
                dclr_mem[i] <= '0;
                filt_mem[i] <= '0;
                hold_mem[i] <= '0;
                out_mem[i] <= '0;
                rise_mem[i] <= '0;
                fall_mem[i] <= '0;
                rsty_mem[i] <= '0;
                fsty_mem[i] <= '0;
                for (int b = 0; b < DATA_W; b++) begin
                    cnt_mem[i][b] <= '0;
                end
            end
        end else begin
            if (clear_cmd) begin
                for (int i = 0; i < SLOTS; i++) begin
                    sset_mem[i] <= '0; // R18
                    sclr_mem[i] <= '0;
                    dset_mem[i] <= '0;
                    dclr_mem[i] <= '0;
                end
            end

            if (slot_wr) begin
                if (bus_field == F_SRC_ADDR) begin
                    src_mem[bus_slot] <= reg_wdata;
                end else if (bus_field == F_DEST_ADDR) begin
                    dst_mem[bus_slot] <= reg_wdata;
                end else if (bus_field == F_FILTER_DEPTH) begin
                    dep_mem[bus_slot] <= (reg_wdata > DATA_W'(DEPTH_MAX)) ?
                        DEPTH_MAX : reg_wdata[DEPTH_W-1:0]; // R4
                end else if (bus_field == F_SAMPLE_SET) begin
                    sset_mem[bus_slot] <= reg_wdata;
                end else if (bus_field == F_SAMPLE_CLEAR) begin
                    sclr_mem[bus_slot] <= reg_wdata;
                end else if (bus_field == F_DRIVE_SET) begin
                    dset_mem[bus_slot] <= reg_wdata;
                end else if (bus_field == F_DRIVE_CLEAR) begin
                    dclr_mem[bus_slot] <= reg_wdata;
                end else if (bus_field == F_OUT_HOLD) begin
                    out_mem[bus_slot] <= reg_wdata;
                end else if (bus_field == F_RISE_STICKY) begin
                    rsty_mem[bus_slot] <= rsty_mem[bus_slot] & ~reg_wdata;
                end else if (bus_field == F_FALL_STICKY) begin
                    fsty_mem[bus_slot] <= fsty_mem[bus_slot] & ~reg_wdata;
                end
            end

            // set beats a same-cycle clear, so no edge is lost
            if (cap) begin
                filt_mem[cur_slot] <= cap_filt;
                hold_mem[cur_slot] <= cap_hold; // R6
                rise_mem[cur_slot] <= cap_rise; // R7
                fall_mem[cur_slot] <= cap_fall; // R8
                rsty_mem[cur_slot] <= (rsty_mem[cur_slot] & ~rsty_wclr) |
                                      cap_rise; // R9
                fsty_mem[cur_slot] <= (fsty_mem[cur_slot] & ~fsty_wclr) |
                                      cap_fall; // R9
                for (int b = 0; b < DATA_W; b++) begin
                    cnt_mem[cur_slot][b] <= cap_cnt[b]; // R3
                end
            end
        end
    end

    // outputs straight from the state register
    assign reg_rdata = r_reg.rdata;
    assign io_req = r_reg.io;
    assign forcing_active = r_reg.forcing_active;
endmodule : sbio_top

// [tb/sbio_io_model.sv]
// partner: i/o registers the scan engine reads and writes
// assumes read data due the cycle after the read strobe
`timescale 1ns/1ps
module sbio_io_model (
    input wire logic core_clk,
    input wire sbio_pkg::sbio_io_req_t io_req,
    output logic [sbio_pkg::DATA_W-1:0] io_rdata
);
    import sbio_pkg::*;
    logic [DATA_W-1:0] mem [64] = '{default: '0};
    int n_wr = 0;
    initial io_rdata = '0;
    // outside a read answer the bus toggles, exposing late captures
    always @(posedge core_clk) begin
        if (io_req.wr) begin
            mem[io_req.addr[7:2]] <= io_req.wdata;
            n_wr++;
        end
        io_rdata <= io_req.rd ? mem[io_req.addr[7:2]] : ~io_rdata;
    end
endmodule : sbio_io_model

// [tb/sbio_checker.sv]
// port-level assertions for the scanned buffered i/o engine
// assumes one clock and async active-low reset; bound into sbio_top
`timescale 1ns/1ps
module sbio_checker (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic fast_tick,
    input wire logic slow_tick,
    input wire logic [sbio_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [sbio_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [sbio_pkg::DATA_W-1:0] reg_rdata,
    input wire sbio_pkg::sbio_io_req_t io_req,
    input wire logic [sbio_pkg::DATA_W-1:0] io_rdata,
    input wire logic forcing_active
);
    import sbio_pkg::*;
    logic en_reg;
    logic [9:0] age_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // enable shadow; cycles since an accepted tick
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            en_reg <= 1'b0;
            age_reg <= 10'h3FF;
        end else begin
            if (reg_wr && reg_addr == REG_CTRL)
                en_reg <= reg_wdata[CTRL_ENABLE_BIT];
            if ((fast_tick || slow_tick) && en_reg)
                age_reg <= 10'h000;
            else if (age_reg != 10'h3FF)
                age_reg <= age_reg + 10'h001;
        end
    end
    property p_act; (io_req.rd || io_req.wr) |-> age_reg < 10'd700; endproperty
    property p_ctrl; reg_rd && reg_addr == REG_CTRL
        |=> reg_rdata == {31'h0, en_reg}; endproperty
    property p_gap; io_req.rd |=> (!io_req.rd) [*2]; endproperty
    property p_order; io_req.rd |=> (!io_req.wr) [*2]; endproperty
    property p_excl; !(io_req.rd && io_req.wr); endproperty
    property p_idle; !$past(reg_rd) |-> reg_rdata == '0; endproperty
    property p_clear; reg_wr && reg_addr == REG_CTRL
        && reg_wdata[CTRL_CLEAR_BIT] |-> ##2 !forcing_active; endproperty
    property p_any; reg_rd && reg_addr == REG_ALL_MASK_ANY
        |=> (reg_rdata != '0) == forcing_active; endproperty
    a_act: assert property (p_act) else $error("i/o access without scan");
    a_ctrl: assert property (p_ctrl) else $error("enable readback");
    a_gap: assert property (p_gap) else $error("input reads too close");
    a_order: assert property (p_order) else $error("write after read");
    a_excl: assert property (p_excl) else $error("read and write");
    a_idle: assert property (p_idle) else $error("read data not zero");
    a_clear: assert property (p_clear) else $error("forcing left on");
    a_any: assert property (p_any) else $error("summary vs flag");
    c_tick: cover property (fast_tick && en_reg);
    c_wr: cover property (io_req.wr);
    c_rd: cover property (io_req.rd);
endmodule : sbio_checker
bind sbio_top sbio_checker i_sbio_checker (.core_clk, .rst_b, .fast_tick,
    .slow_tick, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .io_req, .io_rdata, .forcing_active);

// [tb/tb_scanned_buffered_io.sv]
// bench: scans, debounce, edges, forcing and summaries
// assumes the i/o model answers reads; pokes its memory between scans
`timescale 1ns/1ps
module tb_scanned_buffered_io;
    import sbio_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic fast_tick = 1'b0;
    logic slow_tick = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [DATA_W-1:0] io_rdata;
    logic forcing_active;
    sbio_io_req_t io_req;
    int n_fail = 0;
    int n_compared = 0;
    sbio_top i_sbio_top (.core_clk, .rst_b, .fast_tick, .slow_tick,
        .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .io_req,
        .io_rdata, .forcing_active);
    sbio_io_model i_sbio_io_model (.core_clk, .io_req, .io_rdata);
    initial forever #2.5 core_clk = ~core_clk;
    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [12:0] a, logic [31:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // data stand one cycle only, so sample then
    task automatic rdchk(string what, logic [12:0] a, logic [31:0] exp);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 chk(what, reg_rdata, exp);
    endtask : rdchk
    function automatic logic [12:0] sa(int s, logic [3:0] f);
        return 13'h1000 | 13'(s << 6) | (13'(f) << 2);
    endfunction : sa
    // one tick, then room for the scan
    task automatic scan(logic slow);
        @(posedge core_clk);
        slow_tick <= slow;
        fast_tick <= !slow;
        @(posedge core_clk);
        slow_tick <= 1'b0;
        fast_tick <= 1'b0;
        repeat (24) @(posedge core_clk);
    endtask : scan
    task automatic t_outputs;
        wr(REG_FAST_DRIVE_COUNT, 32'h2);
        wr(sa(0, F_DEST_ADDR), 32'h10);
        wr(sa(0, F_OUT_HOLD), 32'hF0F);
        wr(sa(0, F_DRIVE_SET), 32'hF0000001);
        wr(sa(0, F_DRIVE_CLEAR), 32'hF);
        wr(sa(2, F_DEST_ADDR), 32'h14);
        wr(sa(2, F_OUT_HOLD), 32'h12345678);
        wr(sa(2, F_DRIVE_SET), 32'h00400000);
        scan(1'b0);
        chk("writes off", 32'(i_sbio_io_model.n_wr), 32'h0);
        wr(REG_CTRL, 32'h1);
        scan(1'b0);
        chk("fast out", i_sbio_io_model.mem[4], 32'hF0000F00);
        chk("slow idle", i_sbio_io_model.mem[5], 32'h0);
        scan(1'b1);
        chk("slow out", i_sbio_io_model.mem[5], 32'h12745678);
        chk("writes", 32'(i_sbio_io_model.n_wr), 32'h2);
    endtask : t_outputs
    task automatic t_inputs;
        wr(REG_FAST_IN_COUNT, 32'h1);
        wr(sa(0, F_SRC_ADDR), 32'h40);
        wr(sa(0, F_FILTER_DEPTH), 32'h7);
        rdchk("depth", sa(0, F_FILTER_DEPTH), 32'h4);
        i_sbio_io_model.mem[16] = 32'h1;
        repeat (2) scan(1'b0);
        i_sbio_io_model.mem[16] = 32'h0;
        scan(1'b0);
        i_sbio_io_model.mem[16] = 32'h1;
        repeat (4) scan(1'b0);
        rdchk("hold early", sa(0, F_HOLD_IN), 32'h0);
        scan(1'b0);
        rdchk("hold fifth", sa(0, F_HOLD_IN), 32'h1);
        rdchk("rise", sa(0, F_RISE_PULSE), 32'h1);
        scan(1'b0);
        rdchk("rise gone", sa(0, F_RISE_PULSE), 32'h0);
        wr(sa(0, F_RISE_STICKY), 32'h1);
        rdchk("sticky clr", sa(0, F_RISE_STICKY), 32'h0);
        wr(sa(0, F_FILTER_DEPTH), 32'h0);
        i_sbio_io_model.mem[16] = 32'hFFFF0000;
        wr(sa(0, F_SAMPLE_SET), 32'hF);
        wr(sa(0, F_SAMPLE_CLEAR), 32'h00010005);
        scan(1'b0);
        rdchk("forced", sa(0, F_HOLD_IN), 32'hFFFE000A);
        rdchk("fall", sa(0, F_FALL_PULSE), 32'h1);
        rdchk("fall sticky", sa(0, F_FALL_STICKY), 32'h1);
        rdchk("fast in any", REG_FAST_SAMPLE_ANY, 32'h0001000F);
        rdchk("slow in any", REG_SLOW_SAMPLE_ANY, 32'h0);
        rdchk("fast out any", REG_FAST_DRIVE_ANY, 32'hF000000F);
        rdchk("slow out any", REG_SLOW_DRIVE_ANY, 32'h00400000);
        rdchk("all any", REG_ALL_MASK_ANY, 32'hF041000F);
        chk("forcing", 32'(forcing_active), 32'h1);
        wr(REG_CTRL, 32'h3);
        rdchk("all cleared", REG_ALL_MASK_ANY, 32'h0);
        rdchk("set cleared", sa(0, F_SAMPLE_SET), 32'h0);
        chk("forcing off", 32'(forcing_active), 32'h0);
    endtask : t_inputs
    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        t_outputs();
        t_inputs();
        end_of_test();
    end
    // the run needs about 410 cycles
    initial begin
        #20000;
        n_fail++;
        end_of_test();
    end
endmodule : tb_scanned_buffered_io
